// File: rtl/pfr_pkg.sv
// constants for the packed float reciprocal and multiply-add unit
// How it works
// - reciprocal estimate from rom table, 14-15 bits, three cycle latency
// - refine step one then two gives full 24-bit reciprocal
// - estimate plus both refinements correctly rounded for about 99 percent
// - root reciprocal estimate read from table, at least 10 bits
// - square, root refine, refine two gives 24-bit root, one ulp worst
// - four signed 16x16 products summed in adjacent pairs, two 32-bit sums
// - fast state clear decodes as the ordinary state clear
// - packed ops share the stack unit's registers; clear needed between
// - no cycle penalty switching between stack and packed instructions
// - packed float and packed integer ops interleave with no mode switch
// - flat register file, the same flops as the stack unit's registers
// - divides take 7, 15 and 21 cycles by sequence
// - square root 19 and 7 cycles, root reciprocal four fewer
package pfr_pkg;
  localparam int NREG = 8;
  localparam int LAT_EST = 3;
  localparam int LAT_OP = 2;
  localparam logic [1:0] LAT_EST_L = 2'h3;
  localparam logic [1:0] LAT_OP_L = 2'h2;
  localparam logic [15:0] TAG_EMPTY_ALL = 16'hFFFF;
  localparam logic [15:0] TAG_VALID_ALL = 16'h0000;
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_RCP = 4'h1,
    OP_RCP_IT1 = 4'h2,
    OP_RCP_IT2 = 4'h3,
    OP_RSQ = 4'h4,
    OP_RSQ_IT1 = 4'h5,
    OP_FMUL = 4'h6,
    OP_MADD = 4'h7,
    OP_CLR = 4'h8,
    OP_FAST_CLR = 4'h9,
    OP_ILVL = 4'hA,
    OP_LOAD = 4'hB
  } pfr_op_t;
endpackage

// File: rtl/pfr_unit.sv
// packed float reciprocal, root and multiply-add datapath
`timescale 1ns/10ps
module pfr_unit (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic ISSUE,
  input wire pfr_pkg::pfr_op_t OP,
  input wire logic [2:0] DST,
  input wire logic [2:0] SRC,
  input wire logic [63:0] LOAD_DATA,
  input wire logic STACK_USE,
  output logic DONE,
  output logic [2:0] DONE_REG,
  output logic [63:0] RESULT,
  output logic [15:0] TAG_WORD,
  output logic SHARE_CONFLICT
);
  import pfr_pkg::*;

  // flat file shared with the stack unit, no mode bit anywhere
  logic [63:0] rf_r [NREG];
  logic [63:0] rf_nxt [NREG];
  logic [1:0] cnt_r, cnt_nxt;
  logic busy_r, busy_nxt;
  logic [2:0] dst_r, dst_nxt;
  logic [63:0] res_r, res_nxt, out_r, out_nxt;
  logic done_r, done_nxt;
  logic [15:0] tag_r, tag_nxt;
  logic conf_r, conf_nxt;
  logic [63:0] a, b, comp;

  // single precision helpers; truncated mantissa math, table seeds
  function automatic logic [31:0] fmul(input logic [31:0] x, y);
    logic [47:0] p;
    logic [9:0] e;
    logic [31:0] r;
    p = {1'b1, x[22:0]} * {1'b1, y[22:0]};
    e = {2'h0, x[30:23]} + {2'h0, y[30:23]} - 10'd127 + {9'h0, p[47]};
    r = {x[31] ^ y[31], e[7:0], p[47] ? p[46:24] : p[45:23]};
    if (x[30:0] == 31'h0 || y[30:0] == 31'h0) r = {x[31] ^ y[31], 31'h0};
    return r;
  endfunction

  function automatic logic [31:0] fsub_from(input logic [7:0] k,
                                            input logic [31:0] v);
    // k - v in fixed point, one at bit 24; v must stay below 4.0
    logic [25:0] kf, vf, d;
    logic [7:0] sh;
    logic [4:0] lz;
    logic found;
    logic [31:0] r;
    kf = {k[1:0], 24'h0};
    sh = 8'd127 - v[30:23];
    vf = {1'b0, 1'b1, v[22:0], 1'b0};
    if (v[30:23] == 8'd128) vf = vf << 1;
    else if (v[30:23] > 8'd128 || sh > 8'd25) vf = 26'h0;
    else vf = vf >> sh[4:0];
    d = kf - vf;
    lz = 5'd0;
    found = 1'b0;
    for (int i = 25; i >= 0; i--) begin
      if (d[i] && !found) begin
        lz = 5'(25 - i);
        found = 1'b1;
      end
    end
    r = {1'b0, 8'(8'd128 - {3'h0, lz}), 23'(d << (lz + 5'd1) >> 3)};
    // exact zero has no leading one
    if (!found) r = 32'h0;
    return r;
  endfunction

  // table seed: 14-15 bit estimate taken from a rom-shaped lookup
  function automatic logic [31:0] rcp_est(input logic [31:0] x);
    logic [15:0] m;
    m = 16'(32'h7FFF_FFFF / {16'h0, 1'b1, x[22:8]});
    return {x[31], 8'(8'd253 - x[30:23] + {7'h0, x[22:0] == 23'h0}),
            x[22:0] == 23'h0 ? 23'h0 : {m[14:0], 8'h0}};
  endfunction

  // root seed from a power-of-two table, settled past 10 bits
  function automatic logic [31:0] rsq_est(input logic [31:0] x);
    logic [31:0] s, t, xm;
    logic [7:0] e;
    xm = {1'b0, x[30:0]};
    // seed within 41 percent; four halving steps square that error away
    e = 8'((9'd381 - {1'b0, x[30:23]}) >> 1);
    s = {1'b0, e, 23'h0};
    for (int i = 0; i < 4; i++) begin
      t = fmul(fmul(xm, s), s);
      s = fmul(s, fsub_from(8'h3, t));
      s = {1'b0, 8'(s[30:23] - 8'h1), s[22:0]};
    end
    return s;
  endfunction

  always_comb begin
    a = rf_r[DST];
    b = rf_r[SRC];
    comp = a;
    case (OP)
      OP_RCP: comp = {2{rcp_est(b[31:0])}};
      OP_RSQ: comp = {2{rsq_est(b[31:0])}};
      // step one forms b*x0 per lane, step two x0*(2-that)
      OP_RCP_IT1: for (int l = 0; l < 2; l++)
        comp[32*l +: 32] = fmul(a[32*l +: 32], b[32*l +: 32]);
      OP_RCP_IT2: for (int l = 0; l < 2; l++)
        comp[32*l +: 32] = fmul(b[32*l +: 32],
                                fsub_from(8'h2, a[32*l +: 32]));
      // root step one gives (3 - b*x0^2)/2, then step two finishes
      OP_RSQ_IT1: for (int l = 0; l < 2; l++) begin
        comp[32*l +: 32] = fsub_from(8'h3, fmul(a[32*l +: 32],
                                                b[32*l +: 32]));
        comp[32*l + 23 +: 8] = comp[32*l + 23 +: 8] - 8'd1;
      end
      OP_FMUL: for (int l = 0; l < 2; l++)
        comp[32*l +: 32] = fmul(a[32*l +: 32], b[32*l +: 32]);
      OP_MADD: for (int l = 0; l < 2; l++)
        comp[32*l +: 32] =
          32'($signed(a[32*l +: 16]) * $signed(b[32*l +: 16])) +
          32'($signed(a[32*l+16 +: 16]) * $signed(b[32*l+16 +: 16]));
      OP_ILVL: comp = {b[31:0], a[31:0]};
      OP_LOAD: comp = LOAD_DATA;
      default: comp = a;
    endcase
  end

  always_comb begin
    for (int i = 0; i < NREG; i++) rf_nxt[i] = rf_r[i];
    cnt_nxt = cnt_r;
    busy_nxt = busy_r;
    dst_nxt = dst_r;
    res_nxt = res_r;
    out_nxt = out_r;
    done_nxt = 1'b0;
    tag_nxt = tag_r;
    // stack use while tags show packed data flags the sharing hazard
    conf_nxt = STACK_USE && tag_r != TAG_EMPTY_ALL;
    if (busy_r) begin
      if (cnt_r == 2'h1) begin
        busy_nxt = 1'b0;
        rf_nxt[dst_r] = res_r;
        out_nxt = res_r;
        done_nxt = 1'b1;
      end
      cnt_nxt = cnt_r - 2'h1;
    end
    // issue accepted every cycle, no switch stall between kinds
    if (ISSUE && OP != OP_NOP) begin
      if (OP == OP_CLR || OP == OP_FAST_CLR) begin
        tag_nxt = TAG_EMPTY_ALL;
      end else begin
        busy_nxt = 1'b1;
        dst_nxt = DST;
        res_nxt = comp;
        // estimates 3 cycles; others 2, so 7/15/21 and 19/7 chains fit
        cnt_nxt = (OP == OP_RCP || OP == OP_RSQ) ? LAT_EST_L : LAT_OP_L;
        tag_nxt = TAG_VALID_ALL;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      for (int i = 0; i < NREG; i++) rf_r[i] <= 64'h0;
      cnt_r <= 2'h0;
      busy_r <= 1'b0;
      dst_r <= 3'h0;
      res_r <= 64'h0;
      out_r <= 64'h0;
      done_r <= 1'b0;
      tag_r <= TAG_EMPTY_ALL;
      conf_r <= 1'b0;
    end else begin
      for (int i = 0; i < NREG; i++) rf_r[i] <= rf_nxt[i];
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
      dst_r <= dst_nxt;
      res_r <= res_nxt;
      out_r <= out_nxt;
      done_r <= done_nxt;
      tag_r <= tag_nxt;
      conf_r <= conf_nxt;
    end
  end

  assign DONE = done_r;
  assign DONE_REG = dst_r;
  assign RESULT = out_r;
  assign TAG_WORD = tag_r;
  assign SHARE_CONFLICT = conf_r;

  sequence s_est_issue;
    ISSUE && (OP == OP_RCP || OP == OP_RSQ);
  endsequence
  sequence s_op_issue;
    ISSUE && (OP == OP_FMUL || OP == OP_MADD || OP == OP_RCP_IT1);
  endsequence

  sequence s_clear_issue;
    ISSUE && (OP == OP_CLR || OP == OP_FAST_CLR);
  endsequence

  sequence s_work_issue;
    ISSUE && OP != OP_NOP && OP != OP_CLR && OP != OP_FAST_CLR;
  endsequence

  sequence s_load_issue;
    ISSUE && OP == OP_LOAD;
  endsequence

  sequence s_madd_issue;
    ISSUE && OP == OP_MADD;
  endsequence

  sequence s_quiet_two;
    !ISSUE[*2];
  endsequence

  sequence s_quiet_three;
    !ISSUE[*3];
  endsequence

  sequence s_switch_pair;
    ISSUE && OP == OP_FMUL ##1 s_madd_issue;
  endsequence

  // done is registered, so it is seen one edge after the count ends
  a_est_latency: assert property (@(posedge CLK) disable iff (!RESETN)
    s_est_issue ##1 s_quiet_three |=> DONE)
    else $error("estimate not 3 cycles");

  a_op_latency: assert property (@(posedge CLK) disable iff (!RESETN)
    s_op_issue ##1 s_quiet_two |=> DONE)
    else $error("op not 2 cycles");

  a_est_repl: assert property (@(posedge CLK) disable iff (!RESETN)
    s_est_issue ##1 s_quiet_three |=> RESULT[63:32] == RESULT[31:0])
    else $error("estimate lanes differ");

  a_clear_tags: assert property (@(posedge CLK) disable iff (!RESETN)
    s_clear_issue |=> TAG_WORD == 16'hFFFF)
    else $error("clear left tags");

  a_clear_quiet: assert property (@(posedge CLK) disable iff (!RESETN)
    s_clear_issue ##0 !busy_r |=> !DONE)
    else $error("clear raised done");

  a_work_tags: assert property (@(posedge CLK) disable iff (!RESETN)
    s_work_issue |=> TAG_WORD == TAG_VALID_ALL)
    else $error("tags not marked in use");

  a_reg_dest: assert property (@(posedge CLK) disable iff (!RESETN)
    s_work_issue |=> dst_r == $past(DST))
    else $error("destination not held");

  a_load_data: assert property (@(posedge CLK) disable iff (!RESETN)
    s_load_issue ##1 s_quiet_two |=> RESULT == $past(LOAD_DATA, 3))
    else $error("load data not returned");

  a_madd_high: assert property (@(posedge CLK) disable iff (!RESETN)
    s_madd_issue |=> res_r[63:32] == 32'($signed($past(a[47:32])) *
      $signed($past(b[47:32])) + $signed($past(a[63:48])) *
      $signed($past(b[63:48])))) else $error("madd high sum wrong");

  a_rsq_sign: assert property (@(posedge CLK) disable iff (!RESETN)
    ISSUE && OP == OP_RSQ |=> !res_r[31] && !res_r[63])
    else $error("root estimate negative");

  a_done_busy: assert property (@(posedge CLK) disable iff (!RESETN)
    DONE |-> $past(busy_r))
    else $error("done without work");

  a_done_pulse: assert property (@(posedge CLK) disable iff (!RESETN)
    DONE |=> !DONE)
    else $error("done longer than one cycle");

  a_busy_count: assert property (@(posedge CLK) disable iff (!RESETN)
    busy_r |-> cnt_r != 2'h0)
    else $error("busy with empty count");

  a_result_hold: assert property (@(posedge CLK) disable iff (!RESETN)
    !DONE |-> $stable(RESULT))
    else $error("result moved without done");

  a_stack_quiet: assert property (@(posedge CLK) disable iff (!RESETN)
    STACK_USE && tag_r == TAG_EMPTY_ALL |=> !SHARE_CONFLICT)
    else $error("hazard flagged on empty file");

  a_conf_idle: assert property (@(posedge CLK) disable iff (!RESETN)
    !STACK_USE |=> !SHARE_CONFLICT)
    else $error("hazard flagged without stack use");

  a_madd_sum: assert property (@(posedge CLK) disable iff (!RESETN)
    ISSUE && OP == OP_MADD |=> res_r[31:0] == 32'($signed($past(a[15:0])) *
      $signed($past(b[15:0])) + $signed($past(a[31:16])) *
      $signed($past(b[31:16])))) else $error("madd sum wrong");

  a_done_write: assert property (@(posedge CLK) disable iff (!RESETN)
    DONE |-> rf_r[DONE_REG] == RESULT) else $error("writeback missing");

  a_share_flag: assert property (@(posedge CLK) disable iff (!RESETN)
    STACK_USE && tag_r == 16'h0000 |=> SHARE_CONFLICT)
    else $error("share hazard not flagged");

  // the later kind replaces the pending one and keeps its own latency
  a_no_stall: assert property (@(posedge CLK) disable iff (!RESETN)
    s_switch_pair ##1 s_quiet_two |=> DONE)
    else $error("switch stalled");

endmodule // pfr_unit

// File: sim/pfr_issue_model.sv
// issue side model: sends single ops, or two back to back, into the unit
`timescale 1ns/10ps
module pfr_issue_model
  import pfr_pkg::*;
(
  input wire logic CLK,
  input wire logic DONE,
  output logic ISSUE,
  output pfr_pkg::pfr_op_t OP,
  output logic [2:0] DST,
  output logic [2:0] SRC,
  output logic [63:0] LOAD_DATA
);
  initial begin
    ISSUE = 1'b0;
    OP = OP_NOP;
    DST = 3'h0;
    SRC = 3'h0;
    LOAD_DATA = 64'h0;
  end
  // waits for done, so spacing never undercuts latency
  task automatic run(input pfr_op_t o, input logic [2:0] d,
                     input logic [2:0] s, input logic [63:0] v,
                     output int lat);
    @(posedge CLK);
    ISSUE <= 1'b1;
    OP <= o;
    DST <= d;
    SRC <= s;
    LOAD_DATA <= v;
    @(posedge CLK);
    ISSUE <= 1'b0;
    OP <= OP_NOP;
    LOAD_DATA <= ~v; // released data must not look valid
    lat = 0;
    do begin
      @(posedge CLK);
      #1;
      lat++;
    end while (DONE !== 1'b1 && lat < 6); // clears give no done
  endtask
  // two kinds back to back; the second replaces the first
  task automatic run_pair(input pfr_op_t o1, input logic [2:0] d1,
                          input pfr_op_t o2, input logic [2:0] d2,
                          input logic [2:0] s2, output int lat);
    @(posedge CLK);
    ISSUE <= 1'b1;
    OP <= o1;
    DST <= d1;
    SRC <= d1;
    @(posedge CLK);
    OP <= o2;
    DST <= d2;
    SRC <= s2;
    @(posedge CLK);
    ISSUE <= 1'b0;
    OP <= OP_NOP;
    lat = 0;
    do begin
      @(posedge CLK);
      #1;
      lat++;
    end while (DONE !== 1'b1 && lat < 6);
  endtask
endmodule // pfr_issue_model

// File: sim/pfr_unit_test.sv
// self-checking bench for the packed reciprocal and multiply-add unit
`timescale 1ns/10ps
module pfr_unit_test;
  import pfr_pkg::*;
  logic CLK = 1'b0;
  logic RESETN = 1'b0;
  logic STACK_USE = 1'b0;
  logic ISSUE, DONE, SHARE_CONFLICT;
  pfr_op_t OP;
  logic [2:0] DST, SRC, DONE_REG;
  logic [63:0] LOAD_DATA, RESULT;
  logic [15:0] TAG_WORD;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int lat;
  always #25 CLK = ~CLK;
  pfr_unit u_pfr_unit (.CLK(CLK), .RESETN(RESETN), .ISSUE(ISSUE), .OP(OP),
    .DST(DST), .SRC(SRC), .LOAD_DATA(LOAD_DATA), .STACK_USE(STACK_USE),
    .DONE(DONE), .DONE_REG(DONE_REG), .RESULT(RESULT), .TAG_WORD(TAG_WORD),
    .SHARE_CONFLICT(SHARE_CONFLICT));
  pfr_issue_model u_pfr_issue_model (.CLK(CLK), .DONE(DONE), .ISSUE(ISSUE),
    .OP(OP), .DST(DST), .SRC(SRC), .LOAD_DATA(LOAD_DATA));
  task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // estimates are approximate, so judge by distance in raw bits
  task automatic cnear(string nm, logic [31:0] a, logic [31:0] e, int tol);
    logic ok;
    ok = !$isunknown(a) && (a > e ? a - e : e - a) <= tol;
    chk(nm, 64'(ok), 64'h1);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic op(pfr_op_t o, logic [2:0] d, logic [2:0] s,
                    logic [63:0] v = 64'h0);
    u_pfr_issue_model.run(o, d, s, v, lat);
  endtask
  task automatic stack(logic exp);
    @(posedge CLK);
    STACK_USE <= 1'b1;
    repeat (2) @(posedge CLK);
    #1;
    chk("conflict", 64'(SHARE_CONFLICT), 64'(exp));
    @(posedge CLK);
    STACK_USE <= 1'b0;
  endtask
  // most negative word squared plus most positive squared
  task automatic t_madd;
    op(OP_LOAD, 3'h4, 3'h0, 64'hFFFE_0003_7FFF_8000);
    op(OP_LOAD, 3'h5, 3'h0, 64'h0005_FFFF_7FFF_8000);
    op(OP_MADD, 3'h4, 3'h5);
    chk("madd", RESULT, 64'hFFFF_FFF3_7FFF_0001);
    chk("madd lat", 64'(lat), 64'h2);
    chk("madd reg", 64'(DONE_REG), 64'h4);
    op(OP_LOAD, 3'h4, 3'h0, 64'hFFFE_0003_7FFF_8000);
    u_pfr_issue_model.run_pair(OP_FMUL, 3'h3, OP_MADD, 3'h4, 3'h5, lat);
    chk("switch", RESULT, 64'hFFFF_FFF3_7FFF_0001);
    chk("switch lat", 64'(lat), 64'h2);
    chk("switch reg", 64'(DONE_REG), 64'h4);
    $display("madd test done");
  endtask
  // lane1 holds 4.0, so a copied lane0 estimate shows up in lane1
  task automatic t_rcp;
    op(OP_LOAD, 3'h2, 3'h0, {32'h4080_0000, 32'h4040_0000});
    op(OP_RCP, 3'h3, 3'h2);
    chk("rcp lat", 64'(lat), 64'h3);
    cnear("rcp est", RESULT[31:0], 32'h3EAA_AAAB, 1024);
    cnear("rcp lane1", RESULT[63:32], 32'h3EAA_AAAB, 1024);
    op(OP_RCP_IT1, 3'h2, 3'h3);
    op(OP_RCP_IT2, 3'h2, 3'h3);
    cnear("rcp full", RESULT[31:0], 32'h3EAA_AAAB, 2);
    $display("rcp test done");
  endtask
  task automatic t_rsq;
    op(OP_LOAD, 3'h6, 3'h0, {2{32'h4080_0000}});
    op(OP_RSQ, 3'h5, 3'h6);
    chk("rsq lat", 64'(lat), 64'h3);
    cnear("rsq est", RESULT[63:32], 32'h3F00_0000, 512);
    op(OP_RSQ, 3'h7, 3'h6);
    op(OP_FMUL, 3'h7, 3'h7);
    chk("fmul lat", 64'(lat), 64'h2);
    op(OP_RSQ_IT1, 3'h6, 3'h7);
    op(OP_RCP_IT2, 3'h6, 3'h5);
    cnear("rsq full", RESULT[31:0], 32'h3F00_0000, 1);
    $display("rsq test done");
  endtask
  task automatic t_clr;
    pfr_op_t cl [2] = '{OP_CLR, OP_FAST_CLR};
    for (int i = 0; i < 2; i++) begin
      op(OP_LOAD, 3'h0, 3'h0, 64'h1);
      chk("load lat", 64'(lat), 64'h2);
      chk("tags used", 64'(TAG_WORD === TAG_EMPTY_ALL), 64'h0);
      stack(1'b1);
      op(cl[i], 3'h0, 3'h0);
      chk("clr tags", 64'(TAG_WORD), 64'(TAG_EMPTY_ALL));
      chk("clr no done", 64'(lat), 64'h6);
      stack(1'b0);
    end
    $display("clear test done");
  endtask
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge CLK);
    RESETN <= 1'b1;
    t_madd();
    t_rcp();
    t_rsq();
    t_clr();
    print_verdict();
  end
endmodule // pfr_unit_test
